// [verilog/pcd_decoder.sv]
// Purpose: APB register front and port command decoder
// Assumes: single clock pclk, host writes the control word over APB
// Notes: commands written while one is in progress are ignored
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module pcd_decoder #(
    parameter logic [31:0] TEST_CYCLES = pcd_pkg::ST_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire pcd_pkg::pcd_apb_req_t apb_req,
    output var pcd_pkg::pcd_apb_rsp_t apb_rsp,
    // control block fetch from host memory
    output logic mem_req,
    output logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_data,
    // auxiliary function execution
    output logic aux_exec,
    output logic [7:0] aux_fn,
    input wire logic aux_done,
    // selftest outcome
    input wire pcd_pkg::pcd_test_t test_res,
    // device state and interrupt
    output var pcd_pkg::pcd_dev_t dev_state,
    output logic irq
);
    import pcd_pkg::*;

    pcd_state_t s_ff;
    pcd_state_t nxt_s;
    logic acc;
    logic wr;
    logic rd;
    logic cmd_go;
    logic [3:0] cmd;
    logic [7:0] set_f;
    logic [7:0] clr_f;
    logic [3:0] stv;

    assign acc = apb_req.psel & apb_req.penable & s_ff.rdy;
    assign wr = acc & apb_req.pwrite;
    // read data and read errors are only prepared for reads; unmapped writes answer okay
    assign rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    assign cmd = apb_req.pwdata[3:0];
    // one decode per write, only when idle
    assign cmd_go = wr && apb_req.paddr == OFF_CTRL && !apb_req.pwdata[B_RST]
        && cmd != CMD_NOOP && s_ff.cs == CS_IDLE;

    always_comb begin
        case (s_ff.dev)
            DEV_RESET: stv = STV_RESET;
            DEV_READY: stv = STV_READY;
            DEV_RUN: stv = STV_RUN;
            DEV_LOAD: stv = STV_LOAD;
            default: stv = STV_RESET;
        endcase
    end

    always_comb begin
        nxt_s = s_ff;
        set_f = '0;
        clr_f = '0;
        nxt_s.rdy = apb_req.psel & ~apb_req.penable;
        nxt_s.err = 1'b0;
        nxt_s.mreq = 1'b0;
        nxt_s.aexec = 1'b0;
        if (rd) begin
            nxt_s.rdata = '0;
            case (apb_req.paddr)
                OFF_CTRL: begin
                    nxt_s.rdata[15:FLAG_LO] = s_ff.flags;
                    nxt_s.rdata[B_SUM] = |s_ff.flags;
                    nxt_s.rdata[B_IRQ_ENABLE_BIT] = s_ff.irq_enable_bit;
                    nxt_s.rdata[B_ZERO] = 1'b0;
                end
                OFF_STAT: nxt_s.rdata[15:0] = {1'b0, s_ff.ecode, 4'h0, stv};
                OFF_BLO: nxt_s.rdata[15:0] = s_ff.blo;
                OFF_BHI: nxt_s.rdata[15:0] = s_ff.bhi;
                OFF_MASK: nxt_s.rdata[7:0] = s_ff.mask;
                default: nxt_s.err = 1'b1;
            endcase
        end
        if (wr) begin
            case (apb_req.paddr)
                OFF_CTRL: begin
                    clr_f = apb_req.pwdata[15:FLAG_LO];
                    nxt_s.irq_enable_bit = apb_req.pwdata[B_IRQ_ENABLE_BIT];
                end
                OFF_BLO: nxt_s.blo = apb_req.pwdata[15:0];
                OFF_BHI: nxt_s.bhi = apb_req.pwdata[15:0];
                OFF_MASK: nxt_s.mask = apb_req.pwdata[7:0];
                default: nxt_s.err = 1'b0;
            endcase
        end
        case (s_ff.cs)
            CS_IDLE: begin
                if (cmd_go) begin
                    case (cmd)
                        CMD_LOAD_BASE: begin
                            nxt_s.base = {s_ff.bhi, s_ff.blo};
                            set_f[F_DONE] = 1'b1;
                        end
                        CMD_AUX: begin
                            nxt_s.cs = CS_FETCH;
                            nxt_s.mreq = 1'b1;
                        end
                        CMD_TEST: begin
                            nxt_s.dev = DEV_RESET;
                            nxt_s.cs = CS_TEST;
                            nxt_s.cnt = TEST_CYCLES;
                        end
                        CMD_START: begin
                            nxt_s.dev = DEV_RUN;
                            set_f[F_DONE] = 1'b1;
                        end
                        CMD_BOOT: begin
                            nxt_s.dev = DEV_LOAD;
                            set_f[F_DONE] = 1'b1;
                        end
                        default: set_f[F_DONE] = 1'b1;
                    endcase
                end
            end
            CS_FETCH: begin
                nxt_s.mreq = ~mem_ack;
                if (mem_ack) begin
                    nxt_s.afn = mem_data;
                    nxt_s.aexec = 1'b1;
                    nxt_s.cs = CS_EXEC;
                end
            end
            CS_EXEC: begin
                if (aux_done) begin
                    set_f[F_DONE] = 1'b1;
                    nxt_s.cs = CS_IDLE;
                end
            end
            CS_TEST: begin
                nxt_s.cnt = s_ff.cnt - ONE32;
                if (s_ff.cnt <= ONE32) begin
                    nxt_s.cs = CS_IDLE;
                    if (!test_res.fail) begin
                        set_f[F_DONE] = 1'b1;
                        nxt_s.dev = DEV_READY;
                    end else if (test_res.comm_ok) begin
                        set_f[F_CHG] = 1'b1;
                        nxt_s.ecode = test_res.code;
                    end else begin
                        set_f[F_FATAL_ERROR_FLAG] = 1'b1;
                    end
                end
            end
            default: nxt_s.cs = CS_IDLE;
        endcase
        // set wins over a simultaneous clear
        nxt_s.flags = (s_ff.flags & ~clr_f) | set_f;
        if (wr && apb_req.paddr == OFF_CTRL && apb_req.pwdata[B_RST]) begin
            nxt_s.flags = '0;
            nxt_s.irq_enable_bit = 1'b0;
            nxt_s.dev = DEV_RESET;
            nxt_s.cs = CS_IDLE;
            nxt_s.cnt = '0;
            nxt_s.ecode = '0;
            nxt_s.base = '0;
        end
        nxt_s.irq = nxt_s.irq_enable_bit & |(nxt_s.flags & nxt_s.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
            s_ff.mask <= MASK_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign apb_rsp.prdata = s_ff.rdata;
    assign apb_rsp.pready = s_ff.rdy;
    assign apb_rsp.pslverr = s_ff.err;
    assign mem_req = s_ff.mreq;
    assign mem_addr = s_ff.base;
    assign aux_exec = s_ff.aexec;
    assign aux_fn = s_ff.afn;
    assign dev_state = s_ff.dev;
    assign irq = s_ff.irq;

    logic ctl_wr;
    assign ctl_wr = wr && apb_req.paddr == OFF_CTRL;

    sequence seq_fetch;
        s_ff.mreq && mem_ack;
    endsequence
    sequence seq_exec;
        s_ff.aexec && s_ff.cs == CS_EXEC ##1 s_ff.cs == CS_EXEC;
    endsequence

    AST_SRST: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_wr && apb_req.pwdata[B_RST] |=> s_ff.flags == '0 && s_ff.dev == DEV_RESET && s_ff.cs == CS_IDLE)
        else $error("soft reset did not clear state");
    AST_NOOP: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_wr && cmd == CMD_NOOP && s_ff.cs == CS_IDLE && !s_ff.flags[F_DONE] |=> !s_ff.flags[F_DONE])
        else $error("no-op set done");
    AST_BASE: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cmd == CMD_LOAD_BASE |=> s_ff.base == {$past(s_ff.bhi), $past(s_ff.blo)} && s_ff.flags[F_DONE])
        else $error("base not latched");
    AST_AUX: assert property (@(posedge pclk) disable iff (!presetn)
        seq_fetch |=> seq_exec or (s_ff.aexec ##1 s_ff.cs == CS_IDLE))
        else $error("aux function not executed");
    AST_TEST_RST: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cmd == CMD_TEST |=> s_ff.dev == DEV_RESET && s_ff.cs == CS_TEST && s_ff.cnt == TEST_CYCLES)
        else $error("selftest did not enter reset");
    AST_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        s_ff.cs == CS_TEST && s_ff.cnt <= ONE32 && !test_res.fail && !ctl_wr |=> s_ff.flags[F_DONE] && s_ff.dev == DEV_READY)
        else $error("selftest pass without done");
    AST_CHG: assert property (@(posedge pclk) disable iff (!presetn)
        s_ff.cs == CS_TEST && s_ff.cnt <= ONE32 && test_res.fail && test_res.comm_ok && !ctl_wr
        |=> s_ff.flags[F_CHG] && s_ff.ecode == $past(test_res.code) && s_ff.cs == CS_IDLE)
        else $error("selftest failure not reported");
    AST_FATAL_ERROR_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        s_ff.cs == CS_TEST && s_ff.cnt <= ONE32 && test_res.fail && !test_res.comm_ok && !ctl_wr |=> s_ff.flags[F_FATAL_ERROR_FLAG])
        else $error("fatal flag missing");
    AST_START: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cmd == CMD_START |=> s_ff.dev == DEV_RUN && s_ff.flags[F_DONE])
        else $error("start failed");
    AST_BOOT: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cmd == CMD_BOOT |=> s_ff.dev == DEV_LOAD)
        else $error("boot state not entered");
    AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cmd > CMD_BOOT |=> s_ff.flags[F_DONE] && $stable(s_ff.dev))
        else $error("reserved code misbehaved");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        !s_ff.irq_enable_bit |-> !irq)
        else $error("interrupt while disabled");
    AST_SUM: assert property (@(posedge pclk) disable iff (!presetn)
        rd && apb_req.paddr == OFF_CTRL |=> apb_rsp.prdata[B_SUM] == |$past(s_ff.flags) && !apb_rsp.prdata[B_ZERO])
        else $error("summary or zero bit wrong");
    AST_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
        s_ff.cs != CS_IDLE && !(s_ff.cs == CS_TEST && s_ff.cnt <= ONE32) && ctl_wr && !apb_req.pwdata[B_RST]
        |=> $stable(s_ff.dev))
        else $error("command accepted while busy");
endmodule

`default_nettype wire

// [inc/pcd_pkg.sv]
// Purpose: constants and types of the port command decoder
// Assumes: 32-bit APB, 250 MHz pclk
// Notes: flag bits 15:8 of the control word are write-one-to-clear
package pcd_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_BLO = 8'h08;
    localparam logic [7:0] OFF_BHI = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;
    // control word fields
    localparam int B_RST = 5;
    localparam int B_IRQ_ENABLE_BIT = 6;
    localparam int B_SUM = 7;
    localparam int B_ZERO = 4;
    localparam int FLAG_LO = 8;
    localparam int F_CHG = 0;
    localparam int F_FATAL_ERROR_FLAG = 1;
    localparam int F_DONE = 3;
    localparam logic [7:0] MASK_RST = 8'hFF;
    // status word state field values
    localparam logic [3:0] STV_RESET = 4'h0;
    localparam logic [3:0] STV_READY = 4'h1;
    localparam logic [3:0] STV_RUN = 4'h3;
    localparam logic [3:0] STV_LOAD = 4'h2;
    // selftest duration
    localparam longint ST_SECONDS = 15;
    localparam longint CLK_HZ = 250_000_000;
    localparam logic [31:0] ST_CYCLES = 32'(ST_SECONDS * CLK_HZ);
    localparam logic [31:0] ONE32 = 32'h0000_0001;

    typedef enum logic [3:0] {
        CMD_NOOP = 4'h0,
        CMD_LOAD_BASE = 4'h1,
        CMD_AUX = 4'h2,
        CMD_TEST = 4'h3,
        CMD_START = 4'h4,
        CMD_BOOT = 4'h5
    } pcd_cmd_t;

    typedef enum logic [1:0] {
        DEV_RESET = 2'b00,
        DEV_READY = 2'b01,
        DEV_RUN = 2'b11,
        DEV_LOAD = 2'b10
    } pcd_dev_t;

    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_FETCH = 2'b01,
        CS_EXEC = 2'b11,
        CS_TEST = 2'b10
    } pcd_cs_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pcd_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pcd_apb_rsp_t;

    typedef struct packed {
        logic fail;
        logic comm_ok;
        logic [6:0] code;
    } pcd_test_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic rdy;
        logic err;
        logic [7:0] flags;
        logic irq_enable_bit;
        logic [7:0] mask;
        logic [15:0] blo;
        logic [15:0] bhi;
        logic [31:0] base;
        pcd_dev_t dev;
        pcd_cs_t cs;
        logic [31:0] cnt;
        logic [6:0] ecode;
        logic mreq;
        logic aexec;
        logic [7:0] afn;
        logic irq;
    } pcd_state_t;
endpackage

// [test/pcd_host_mem.sv]
// Purpose: host-memory and auxiliary-unit model facing the decoder
// Assumes: one mem_ack per fetch, one aux_done per aux_exec
// Notes: DLY sets how slowly both answers come
`timescale 1ns/1ns
`default_nettype none
module pcd_host_mem #(
    parameter int DLY = 3,
    parameter logic [7:0] FN = 8'h5A
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control block fetch
    input wire logic mem_req,
    output logic mem_ack,
    output logic [7:0] mem_data,
    // aux execution
    input wire logic aux_exec,
    output logic aux_done
);
    int mcnt;
    int acnt;
    logic abusy;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcnt <= 0;
            acnt <= 0;
            abusy <= 1'b0;
            mem_ack <= 1'b0;
            aux_done <= 1'b0;
            mem_data <= ~FN;
        end else begin
            mem_ack <= 1'b0;
            aux_done <= 1'b0;
            // data line floats to the inverse outside the ack cycle
            mem_data <= ~FN;
            mcnt <= mem_req ? mcnt + 1 : 0;
            if (mem_req && !mem_ack && mcnt == DLY) begin
                mem_ack <= 1'b1;
                mem_data <= FN;
                mcnt <= 0;
            end
            if (aux_exec) begin
                abusy <= 1'b1;
                acnt <= 0;
            end else if (abusy) begin
                acnt <= acnt + 1;
                if (acnt == DLY) begin
                    aux_done <= 1'b1;
                    abusy <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Purpose: self-checking bench of the port command decoder
// Assumes: APB without wait states, selftest shortened to 20 cycles
// Notes: flags are polled through the control word
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pcd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    pcd_apb_req_t req = '0;
    pcd_apb_rsp_t rsp;
    logic mem_req, mem_ack, aux_exec, aux_done, irq, er;
    logic [31:0] mem_addr, rd;
    logic [31:0] nex = '0;
    logic [7:0] mem_data, aux_fn;
    pcd_test_t tres = '0;
    pcd_dev_t dev;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    always #2 pclk = ~pclk;
    pcd_decoder #(.TEST_CYCLES(32'h0000_0014)) pcd_decoder_inst (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_data(mem_data), .aux_exec(aux_exec), .aux_fn(aux_fn), .aux_done(aux_done),
        .test_res(tres), .dev_state(dev), .irq(irq));
    pcd_host_mem pcd_host_mem_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_ack(mem_ack), .mem_data(mem_data), .aux_exec(aux_exec), .aux_done(aux_done));
    always @(posedge pclk) begin
        if (aux_exec === 1'b1) nex <= nex + 1;
    end
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // host waits far beyond the shortened selftest
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            $display("[ERR] %0t timeout", $time);
            complete_run;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        apb(1'b0, a, '0);
        chk(rd & msk, exp);
    endtask
    // issue a command, wait for a flag, check and clear it
    task run(input logic [3:0] c, input logic [31:0] exp, input logic cd, input pcd_dev_t d);
        int n;
        apb(1'b1, OFF_CTRL, {28'h000_0004, c});
        @(posedge pclk);
        if (cd) chk({30'h0, dev}, {30'h0, d});
        n = 0;
        rd = '0;
        while (rd[15:8] == 8'h00 && n < 100) begin
            apb(1'b0, OFF_CTRL, '0);
            n++;
        end
        chk(rd, exp);
        chk({31'h0, irq}, ONE32);
        apb(1'b1, OFF_CTRL, exp);
        rdchk(OFF_CTRL, 32'h0000_0040, '1);
        chk({31'h0, irq}, '0);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(OFF_MASK, 32'h0000_00FF, '1);
        rdchk(OFF_CTRL, '0, '1);
        apb(1'b0, 8'h14, '0);
        chk({31'h0, er}, ONE32);
        // unmapped write is dropped without an error
        apb(1'b1, 8'h14, 32'h0000_FFFF);
        chk({31'h0, er}, '0);
        wr_noop();
        run(4'h6, 32'h0000_08C0, 1'b0, DEV_RESET);
        run(4'h7, 32'h0000_08C0, 1'b0, DEV_RESET);
        apb(1'b1, OFF_BLO, 32'h0000_1234);
        apb(1'b1, OFF_BHI, 32'h0000_ABCD);
        run(4'h1, 32'h0000_08C0, 1'b0, DEV_RESET);
        chk(mem_addr, 32'hABCD_1234);
        run(4'h2, 32'h0000_08C0, 1'b0, DEV_RESET);
        chk({24'h0, aux_fn}, 32'h0000_005A);
        chk(nex, ONE32);
        run(4'h3, 32'h0000_08C0, 1'b1, DEV_RESET);
        tres <= {1'b1, 1'b1, 7'h2A};
        run(4'h3, 32'h0000_01C0, 1'b1, DEV_RESET);
        rdchk(OFF_STAT, 32'h0000_2A00, 32'h0000_7F00);
        tres <= '0;
        run(4'h4, 32'h0000_08C0, 1'b1, DEV_RUN);
        run(4'h4, 32'h0000_08C0, 1'b1, DEV_RUN);
        run(4'h5, 32'h0000_08C0, 1'b1, DEV_LOAD);
        apb(1'b1, OFF_MASK, 32'h0000_00F7);
        apb(1'b1, OFF_CTRL, 32'h0000_0046);
        repeat (4) @(posedge pclk);
        rdchk(OFF_CTRL, 32'h0000_08C0, '1);
        chk({31'h0, irq}, '0);
        apb(1'b1, OFF_MASK, 32'h0000_00FF);
        rdchk(OFF_MASK, 32'h0000_00FF, '1);
        chk({31'h0, irq}, ONE32);
        apb(1'b1, OFF_CTRL, 32'h0000_0000);
        rdchk(OFF_CTRL, 32'h0000_0880, '1);
        chk({31'h0, irq}, '0);
        apb(1'b1, OFF_CTRL, 32'h0000_0840);
        tres <= {1'b1, 1'b0, 7'h00};
        run(4'h3, 32'h0000_02C0, 1'b1, DEV_RESET);
        tres <= '0;
        // a start written during selftest is dropped
        apb(1'b1, OFF_CTRL, 32'h0000_0043);
        apb(1'b1, OFF_CTRL, 32'h0000_0044);
        @(posedge pclk);
        chk({30'h0, dev}, {30'h0, DEV_RESET});
        repeat (30) @(posedge pclk);
        rdchk(OFF_CTRL, 32'h0000_08C0, '1);
        chk({30'h0, dev}, {30'h0, DEV_READY});
        // soft reset with done still set and device ready
        apb(1'b1, OFF_CTRL, 32'h0000_0020);
        rdchk(OFF_CTRL, '0, '1);
        chk({30'h0, dev}, {30'h0, DEV_RESET});
        chk(mem_addr, '0);
        complete_run;
    end
    // noop with bit 4 written leaves only the enable
    task wr_noop;
        apb(1'b1, OFF_CTRL, 32'h0000_0050);
        repeat (3) @(posedge pclk);
        rdchk(OFF_CTRL, 32'h0000_0040, '1);
    endtask
endmodule
`default_nettype wire
